// *** ocad_consts.svh ***
/*
 * Address map, register offsets, field positions and timing counts of the
 * on-chip address decoder.
 * Assumes it is included by bare name from the package file only.
 */
`ifndef OCAD_CONSTS_SVH
`define OCAD_CONSTS_SVH

// Flash blocks, user and bootstrap map (24-bit byte addresses)
`define OCAD_TFLASH_LO   24'h000000
`define OCAD_TFLASH_HI   24'h001fff
`define OCAD_FLASH03_LO  24'h000000
`define OCAD_FLASH03_HI  24'h007fff
`define OCAD_FLASH4_LO   24'h018000
`define OCAD_FLASH4_HI   24'h01ffff
`define OCAD_FLASH5_LO   24'h020000
`define OCAD_FLASH5_HI   24'h02ffff
`define OCAD_RSVD_LO     24'h030000
`define OCAD_RSVD_HI     24'h04ffff
`define OCAD_BLK_SHIFT   13
// Extension RAM area 1 and the CAN windows
`define OCAD_EXT_RAM_AREA1_LO    24'h00e000
`define OCAD_EXT_RAM_AREA1_HI    24'h00e7ff
`define OCAD_CAN1_LO     24'h00ef00
`define OCAD_CAN1_HI     24'h00efff
`define OCAD_CAN2_LO     24'h00ee00
`define OCAD_CAN2_HI     24'h00eeff
// Internal RAM and the two 512-byte register areas
`define OCAD_DUAL_PORT_INTERNAL_RAM_LO     24'h00f600
`define OCAD_DUAL_PORT_INTERNAL_RAM_HI     24'h00fdff
`define OCAD_SFR_LO      24'h00fe00
`define OCAD_SFR_HI      24'h00ffff
`define OCAD_EXTENDED_FUNCTION_REGS_LO     24'h00f000
`define OCAD_EXTENDED_FUNCTION_REGS_HI     24'h00f1ff
// Area 2 base: address bits 23..14 held in the select register
`define OCAD_RAM2_BASE_W 10
`define OCAD_RAM2_BASE_RST 10'h024
`define OCAD_RAM2_SEL_BIT 13

// Register byte offsets on the APB slave
`define OCAD_OFF_SYSCFG  12'h000
`define OCAD_OFF_PERIPH  12'h004
`define OCAD_OFF_RAM2SEL 12'h008
`define OCAD_OFF_STATUS  12'h00c
`define OCAD_OFF_ADRSEL0 12'h010
`define OCAD_OFF_BUSCFG0 12'h020
`define OCAD_EXT_WIN     4

// Field positions
`define OCAD_SYS_GLOBAL_BIT 2
`define OCAD_PER_CAN1_BIT   0
`define OCAD_PER_CAN2_BIT   1
`define OCAD_PER_RAM1_BIT   2
`define OCAD_PER_RAM2_BIT   3
`define OCAD_SYSCFG_RST     16'h0000
`define OCAD_PERIPH_RST     16'h0000
`define OCAD_ADRSEL_RST     16'h0000
`define OCAD_BUSCFG_RST     16'h0000

// Segment lines on port 4
`define OCAD_SEG_ALL  4'h8
`define OCAD_SEG_CAN  4'h4

// Access times and the clock
`define OCAD_CLK_PERIOD_PS 4000
`define OCAD_XRAM_ACC_PS   31250
`define OCAD_CAN_ACC_PS    62500
`define OCAD_CYC(ps) (((ps) + `OCAD_CLK_PERIOD_PS - 1) / `OCAD_CLK_PERIOD_PS)
`define OCAD_XRAM_WAIT_ST  2'h0
`define OCAD_CAN_WAIT_ST   2'h2
`define OCAD_CNT_W         5

`endif

// *** ocad_pkg.sv ***
/*
 * Types of the on-chip address decoder: targets, access request, answer.
 * Assumes ocad_consts.svh is on the include path.
 */
`include "ocad_consts.svh"

package ocad_pkg;

   typedef enum logic [3:0] {
      OCAD_TGT_FLASH,
      OCAD_TGT_RESERVED,
      OCAD_TGT_DUAL_PORT_INTERNAL_RAM,
      OCAD_TGT_EXT_RAM_AREA1,
      OCAD_TGT_EXT_RAM_AREA2,
      OCAD_TGT_SFR,
      OCAD_TGT_EXTENDED_FUNCTION_REGS,
      OCAD_TGT_CAN1,
      OCAD_TGT_CAN2,
      OCAD_TGT_EXT
   } ocad_target_t;

   typedef struct packed {
      logic [23:0] addr;      // Byte address
      logic        write;     // 1 write, 0 read
      logic        byte_acc;  // 1 byte access, 0 word access
   } ocad_req_t;

   typedef struct packed {
      ocad_target_t target;     // Selected target
      logic [2:0]   flash_blk;  // 0..5 user blocks, 6 test block
      logic [1:0]   wait_st;    // Wait states of the target
      logic         width16;    // 16-bit data path
      logic         bit_addr;   // Target is bit addressable
      logic         size_err;   // Byte access to word-only target
      logic [1:0]   ext_win;    // Matching external window
      logic [15:0]  ext_cfg;    // Bus configuration for external access
   } ocad_resp_t;

endpackage : ocad_pkg

// *** ocad_decoder.sv ***
/*
 * On-chip address decoder: steers each CPU access to flash, internal RAM,
 * extension RAM areas, register areas, CAN windows or the external bus,
 * and paces the answer by the target's access time. Configuration over APB.
 * Assumes one 250 MHz clock, a CPU that holds its request until ready,
 * and a static bootstrap strap pin.
 * Limitation: one access is in flight at a time; a request made while
 * the sequencer is busy is not queued, it simply waits for ready.
 * Trade-off: access times are rounded up to whole cycles, so a target
 * is never cut short, at the cost of a little throughput.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bootstrap maps test block at zero
// - User mode maps six flash blocks
// - One 16 MB space, byte and word
// - Internal RAM holds data, stack, code, banks
// - Extension RAM zero-wait, byte and word
// - Area 1 needs global and own enable
// - Disabled area 1 goes to external bus
// - Area 2 at programmed base when enabled
// - Global disable sends area 2 external
// - Area 2 resets to 09'0000h, mirrors 16K; code keeps 8K, upper 8K of the 16K step external
// - Two 512-byte register areas reserved
// - First CAN window needs both enables
// - Second CAN window needs both enables
// - CAN word only, two wait states
// - CAN use limits segment lines to four
module ocad_decoder
   import ocad_pkg::*;
(
   input  wire logic        REF_CLK,    // 250 MHz clock
   input  wire logic        RESETN,     // Asynchronous reset, active low
   input  wire logic        PSEL,       // APB select
   input  wire logic        PENABLE,    // APB access phase
   input  wire logic        PWRITE,     // APB direction
   input  wire logic [11:0] PADDR,      // APB byte address
   input  wire logic [31:0] PWDATA,     // APB write data
   output logic [31:0]      PRDATA,     // APB read data
   output logic             PREADY,     // APB ready
   output logic             PSLVERR,    // APB error on unmapped address
   input  wire logic        BOOT_MODE,  // Bootstrap strap pin
   input  wire logic        ACC_VALID,  // CPU access request
   output logic             ACC_READY,  // Decoder takes a request
   input  wire ocad_req_t   ACC_REQ,    // Address and kind of access
   output logic             ACC_DONE,   // Access complete, one cycle
   output ocad_resp_t       ACC_RESP,   // Decode of the last access
   output logic [3:0]       SEG_LINES   // Segment lines allowed on port 4
);

   // Access times of the slow targets in whole clock cycles
   localparam int XRAM_CYC = `OCAD_CYC(`OCAD_XRAM_ACC_PS);
   localparam int CAN_CYC  = `OCAD_CYC(`OCAD_CAN_ACC_PS);

   // Idle takes a request, wait counts the access, done answers once
   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DONE} ocad_state_t;

   // Configuration registers
   logic [15:0] syscfg_r, syscfg_nxt;
   logic [15:0] periph_r, periph_nxt;
   logic [`OCAD_RAM2_BASE_W-1:0] ram2_base_r, ram2_base_nxt;
   logic [15:0] adrsel_r [`OCAD_EXT_WIN];
   logic [15:0] adrsel_nxt [`OCAD_EXT_WIN];
   logic [15:0] buscfg_r [`OCAD_EXT_WIN];
   logic [15:0] buscfg_nxt [`OCAD_EXT_WIN];
   logic [31:0] prdata_r, prdata_nxt;
   logic        pslverr_nxt;
   // Strap synchroniser and latched mode
   logic        boot_s1_r, boot_s2_r, boot_s3_r;
   logic        boot_r, boot_nxt;
   // Access sequencer
   ocad_state_t state_r, state_nxt;
   logic [`OCAD_CNT_W-1:0] cnt_r, cnt_nxt;
   ocad_resp_t  resp_r, resp_nxt;
   ocad_resp_t  dec;
   logic [`OCAD_CNT_W-1:0] dec_cyc;
   // Decode helpers
   logic        g_en, ram1_on, ram2_on, can1_on, can2_on;
   logic [`OCAD_EXT_WIN-1:0] win_hit;
   logic        apb_wr, apb_rd, reg_hit;

   // Inclusive range test on a 24-bit byte address
   function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                   input logic [23:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   // Effective enables, taken from the live registers each access
   assign g_en    = syscfg_r[`OCAD_SYS_GLOBAL_BIT];
   assign ram1_on = g_en && periph_r[`OCAD_PER_RAM1_BIT];
   assign ram2_on = g_en && periph_r[`OCAD_PER_RAM2_BIT];
   assign can1_on = g_en && periph_r[`OCAD_PER_CAN1_BIT];
   assign can2_on = g_en && periph_r[`OCAD_PER_CAN2_BIT];

   // External windows: base in bits 15..4 (address 23..12), size 4K << code
   // A size code of 12 or more clears the mask, so the window spans all
   genvar gi;
   generate
      for (gi = 0; gi < `OCAD_EXT_WIN; gi++) begin : g_win
         logic [11:0] mask;
         assign mask = ~((12'h001 << adrsel_r[gi][3:0]) - 12'h001);
         assign win_hit[gi] = ((ACC_REQ.addr[23:12] ^ adrsel_r[gi][15:4]) & mask) == 12'h000;
      end
   endgenerate

   // Address decode; on-chip targets are tested first so an external
   // window that overlaps them never sees the access
   always_comb begin
      dec           = '0;
      dec.target    = OCAD_TGT_EXT;
      dec.width16   = 1'b1;
      dec.flash_blk = 3'h0;
      dec_cyc       = `OCAD_CNT_W'(1);
      // Lowest window wins when several external windows match
      // No hit at all leaves window 0 and its bus configuration
      for (int i = `OCAD_EXT_WIN - 1; i >= 0; i--) begin
         if (win_hit[i]) begin
            dec.ext_win = 2'(i);
         end
      end
      dec.ext_cfg = buscfg_r[dec.ext_win];
      if (boot_r && in_rng(ACC_REQ.addr, `OCAD_TFLASH_LO, `OCAD_TFLASH_HI)) begin
         dec.target    = OCAD_TGT_FLASH;
         dec.flash_blk = 3'h6;
      end else if (in_rng(ACC_REQ.addr, `OCAD_FLASH03_LO, `OCAD_FLASH03_HI)) begin
         dec.target    = OCAD_TGT_FLASH;
         dec.flash_blk = {1'b0, ACC_REQ.addr[`OCAD_BLK_SHIFT+1:`OCAD_BLK_SHIFT]};
      end else if (in_rng(ACC_REQ.addr, `OCAD_FLASH4_LO, `OCAD_FLASH4_HI)) begin
         dec.target    = OCAD_TGT_FLASH;
         dec.flash_blk = 3'h4;
      end else if (in_rng(ACC_REQ.addr, `OCAD_FLASH5_LO, `OCAD_FLASH5_HI)) begin
         dec.target    = OCAD_TGT_FLASH;
         dec.flash_blk = 3'h5;
      end else if (in_rng(ACC_REQ.addr, `OCAD_RSVD_LO, `OCAD_RSVD_HI)) begin
         // Still answered by flash cells; the system must not use it
         dec.target    = OCAD_TGT_RESERVED;
      end else if (ram1_on && in_rng(ACC_REQ.addr, `OCAD_EXT_RAM_AREA1_LO, `OCAD_EXT_RAM_AREA1_HI)) begin
         // No wait state, yet the answer still takes the full access time
         dec.target    = OCAD_TGT_EXT_RAM_AREA1;
         dec.wait_st   = `OCAD_XRAM_WAIT_ST;
         dec_cyc       = `OCAD_CNT_W'(XRAM_CYC);
      end else if (can1_on && in_rng(ACC_REQ.addr, `OCAD_CAN1_LO, `OCAD_CAN1_HI)) begin
         // Word only: a byte access is still answered, but flagged
         dec.target    = OCAD_TGT_CAN1;
         dec.wait_st   = `OCAD_CAN_WAIT_ST;
         dec.size_err  = ACC_REQ.byte_acc;
         dec_cyc       = `OCAD_CNT_W'(CAN_CYC);
      end else if (can2_on && in_rng(ACC_REQ.addr, `OCAD_CAN2_LO, `OCAD_CAN2_HI)) begin
         dec.target    = OCAD_TGT_CAN2;
         dec.wait_st   = `OCAD_CAN_WAIT_ST;
         dec.size_err  = ACC_REQ.byte_acc;
         dec_cyc       = `OCAD_CNT_W'(CAN_CYC);
      end else if (ram2_on && ACC_REQ.addr[23:24-`OCAD_RAM2_BASE_W] == ram2_base_r
                   && !ACC_REQ.addr[`OCAD_RAM2_SEL_BIT]) begin
         // Bit 13 low: 8K area in the lower half of the 16K step of the base
         dec.target    = OCAD_TGT_EXT_RAM_AREA2;
         dec.wait_st   = `OCAD_XRAM_WAIT_ST;
         dec_cyc       = `OCAD_CNT_W'(XRAM_CYC);
      end else if (in_rng(ACC_REQ.addr, `OCAD_DUAL_PORT_INTERNAL_RAM_LO, `OCAD_DUAL_PORT_INTERNAL_RAM_HI)) begin
         // Internal RAM and register areas are bit addressable
         dec.target    = OCAD_TGT_DUAL_PORT_INTERNAL_RAM;
         dec.bit_addr  = 1'b1;
      end else if (in_rng(ACC_REQ.addr, `OCAD_SFR_LO, `OCAD_SFR_HI)) begin
         dec.target    = OCAD_TGT_SFR;
         dec.bit_addr  = 1'b1;
      end else if (in_rng(ACC_REQ.addr, `OCAD_EXTENDED_FUNCTION_REGS_LO, `OCAD_EXTENDED_FUNCTION_REGS_HI)) begin
         dec.target    = OCAD_TGT_EXTENDED_FUNCTION_REGS;
         dec.bit_addr  = 1'b1;
      end
      // Anything else, disabled windows included, stays external
   end

   // Access sequencer: take, count the access time, pulse done
   // A request made while busy is ignored until ready returns
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      resp_nxt  = resp_r;
      case (state_r)
         S_IDLE: begin
            if (ACC_VALID) begin
               resp_nxt = dec;
               // One-cycle targets go straight to done
               if (dec_cyc > `OCAD_CNT_W'(1)) begin
                  cnt_nxt   = dec_cyc - `OCAD_CNT_W'(1);
                  state_nxt = S_WAIT;
               end else begin
                  state_nxt = S_DONE;
               end
            end
         end
         S_WAIT: begin
            cnt_nxt = cnt_r - `OCAD_CNT_W'(1);
            if (cnt_r == `OCAD_CNT_W'(1)) begin
               state_nxt = S_DONE;
            end
         end
         S_DONE: begin
            state_nxt = S_IDLE;
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= S_IDLE;
         cnt_r   <= '0;
         resp_r  <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         resp_r  <= resp_nxt;
      end
   end

   assign ACC_READY = (state_r == S_IDLE);
   assign ACC_DONE  = (state_r == S_DONE);
   assign ACC_RESP  = resp_r;

   // Fewer segment lines whenever a CAN module holds its pins
   // Limitation: follows the enable bits, not whether the pins are in use
   assign SEG_LINES = (can1_on || can2_on) ? `OCAD_SEG_CAN : `OCAD_SEG_ALL;

   // Strap: three stages, mode follows once stages two and three agree
   // Stage one may be metastable, so only stages two and three are read
   always_comb begin
      boot_nxt = boot_r;
      if (boot_s2_r == boot_s3_r) begin
         boot_nxt = boot_s3_r;
      end
   end

   // Strap stages and the latched mode
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         boot_s1_r <= 1'b0;
         boot_s2_r <= 1'b0;
         boot_s3_r <= 1'b0;
         boot_r    <= 1'b0;
      end else begin
         boot_s1_r <= BOOT_MODE;
         boot_s2_r <= boot_s1_r;
         boot_s3_r <= boot_s2_r;
         boot_r    <= boot_nxt;
      end
   end

   // APB slave: zero-wait, writes at the access phase, error if unmapped.
   // Read data is fetched at the end of the setup phase, so PRDATA comes
   // straight from a flip-flop and still stands in the access phase
   assign apb_wr = PSEL && PENABLE && PWRITE;
   assign apb_rd = PSEL && !PENABLE && !PWRITE;

   // Register file: next values, read selection and the error flag
   always_comb begin
      syscfg_nxt    = syscfg_r;
      periph_nxt    = periph_r;
      ram2_base_nxt = ram2_base_r;
      adrsel_nxt    = adrsel_r;
      buscfg_nxt    = buscfg_r;
      prdata_nxt    = prdata_r;
      reg_hit       = 1'b1;
      case (PADDR)
         `OCAD_OFF_SYSCFG: begin
            if (apb_wr) syscfg_nxt = PWDATA[15:0];
            prdata_nxt = {16'h0000, syscfg_r};
         end
         `OCAD_OFF_PERIPH: begin
            if (apb_wr) periph_nxt = PWDATA[15:0];
            prdata_nxt = {16'h0000, periph_r};
         end
         `OCAD_OFF_RAM2SEL: begin
            if (apb_wr) ram2_base_nxt = PWDATA[`OCAD_RAM2_BASE_W-1:0];
            prdata_nxt = {22'h000000, ram2_base_r};
         end
         `OCAD_OFF_STATUS: begin
            // Live state: strap mode, segment lines, last target, ready
            prdata_nxt = {20'h00000, ACC_READY, boot_r, SEG_LINES, 2'h0, resp_r.target};
         end
         default: begin
            // Window selects and bus configurations sit at stepped offsets
            reg_hit = 1'b0;
            for (int i = 0; i < `OCAD_EXT_WIN; i++) begin
               if (PADDR == `OCAD_OFF_ADRSEL0 + 12'(4 * i)) begin
                  reg_hit = 1'b1;
                  if (apb_wr) adrsel_nxt[i] = PWDATA[15:0];
                  prdata_nxt = {16'h0000, adrsel_r[i]};
               end
               if (PADDR == `OCAD_OFF_BUSCFG0 + 12'(4 * i)) begin
                  reg_hit = 1'b1;
                  if (apb_wr) buscfg_nxt[i] = PWDATA[15:0];
                  prdata_nxt = {16'h0000, buscfg_r[i]};
               end
            end
            if (!reg_hit) prdata_nxt = 32'h00000000;
         end
      endcase
      if (!apb_rd) prdata_nxt = prdata_r;
      pslverr_nxt = PSEL && !reg_hit;
   end

   // Read data is registered; PRDATA shows it in the setup-to-access path
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         syscfg_r    <= `OCAD_SYSCFG_RST;
         periph_r    <= `OCAD_PERIPH_RST;
         ram2_base_r <= `OCAD_RAM2_BASE_RST;
         for (int i = 0; i < `OCAD_EXT_WIN; i++) begin
            adrsel_r[i] <= `OCAD_ADRSEL_RST;
            buscfg_r[i] <= `OCAD_BUSCFG_RST;
         end
         prdata_r    <= 32'h00000000;
      end else begin
         syscfg_r    <= syscfg_nxt;
         periph_r    <= periph_nxt;
         ram2_base_r <= ram2_base_nxt;
         adrsel_r    <= adrsel_nxt;
         buscfg_r    <= buscfg_nxt;
         prdata_r    <= prdata_nxt;
      end
   end

   // Registered read data; it holds the last value between reads. A live
   // status bit may move between setup and access; the value seen at the
   // setup edge is the one shown
   assign PRDATA  = prdata_r;
   assign PREADY  = 1'b1;
   assign PSLVERR = pslverr_nxt && PENABLE;

endmodule : ocad_decoder

`default_nettype wire

// *** ocad_decoder_props.sv ***
/* Checker for the decoder's access port.
   Assumes binding to ocad_decoder, one clock, reset active low. */
`timescale 1ns/1ps
`default_nettype none
module ocad_decoder_props
   import ocad_pkg::*;
(
   input wire logic        REF_CLK,   // Clock
   input wire logic        RESETN,    // Reset
   input wire logic        PSEL,      // APB select
   input wire logic        PENABLE,   // APB enable
   input wire logic        PWRITE,    // APB write
   input wire logic [11:0] PADDR,     // APB address
   input wire logic [31:0] PWDATA,    // APB data
   input wire logic [31:0] PRDATA,    // APB read data
   input wire logic        PREADY,    // APB ready
   input wire logic        PSLVERR,   // APB error
   input wire logic        BOOT_MODE, // Strap
   input wire logic        ACC_VALID, // Request
   input wire logic        ACC_READY, // Idle
   input wire ocad_req_t   ACC_REQ,   // Access
   input wire logic        ACC_DONE,  // Done
   input wire ocad_resp_t  ACC_RESP,  // Decode
   input wire logic [3:0]  SEG_LINES  // Segment lines
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   logic take, xr, cn;
   // Decode of the take and of the answered target
   assign take = ACC_VALID && ACC_READY;
   assign xr = ACC_DONE && ACC_RESP.target inside {OCAD_TGT_EXT_RAM_AREA1, OCAD_TGT_EXT_RAM_AREA2};
   assign cn = ACC_DONE && ACC_RESP.target inside {OCAD_TGT_CAN1, OCAD_TGT_CAN2};

   flash_map_a: assert property (take && ACC_REQ.addr <= 24'h007fff |=>
      ACC_DONE && ACC_RESP.target == OCAD_TGT_FLASH) else $error("flash map");
   rsvd_map_a: assert property (take && ACC_REQ.addr inside {[24'h030000:24'h04ffff]}
      |=> ACC_DONE && ACC_RESP.target == OCAD_TGT_RESERVED) else $error("reserved map");
   busy_hold_a: assert property (take |=> !ACC_READY) else $error("ready during access");
   done_pulse_a: assert property (ACC_DONE |=> !ACC_DONE && ACC_READY)
      else $error("done not one cycle");
   xram_time_a: assert property (xr |-> $past(ACC_READY, 8) && !$past(ACC_READY, 7))
      else $error("extension RAM time");
   xram_attr_a: assert property (xr |-> ACC_RESP.wait_st == 2'h0 && ACC_RESP.width16
      && !ACC_RESP.bit_addr && !ACC_RESP.size_err) else $error("extension RAM kind");
   can_time_a: assert property (cn |-> $past(ACC_READY, 16) && !$past(ACC_READY, 15))
      else $error("CAN time");
   can_attr_a: assert property (cn |-> ACC_RESP.wait_st == 2'h2 && ACC_RESP.width16)
      else $error("CAN kind");
   can_seg_a: assert property (cn |-> SEG_LINES == 4'h4) else $error("segment lines");
endmodule : ocad_decoder_props

bind ocad_decoder ocad_decoder_props u_props (.REF_CLK(REF_CLK), .RESETN(RESETN),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BOOT_MODE(BOOT_MODE),
   .ACC_VALID(ACC_VALID), .ACC_READY(ACC_READY), .ACC_REQ(ACC_REQ),
   .ACC_DONE(ACC_DONE), .ACC_RESP(ACC_RESP), .SEG_LINES(SEG_LINES));
`default_nettype wire

// *** ocad_cpu_model.sv ***
/* CPU side model: issues one access at a time and waits for its answer.
   Assumes the decoder's ready, done and registered answer. */
`timescale 1ns/1ps
`default_nettype none
module ocad_cpu_model
   import ocad_pkg::*;
(
   input  wire logic       clk,   // Clock
   input  wire logic       ready, // Decoder idle
   input  wire logic       done,  // Answer pulse
   input  wire ocad_resp_t resp,  // Answer
   output var  logic       valid, // Request
   output var  ocad_req_t  req    // Access
);
   initial valid = 1'b0;
   initial req = '0;
   // Request held until taken; reads only, no bit operations
   task automatic access(input logic [23:0] a, input logic b, output ocad_resp_t r);
      @(posedge clk);
      valid <= 1'b1;
      req <= '{addr: a, write: 1'b0, byte_acc: b};
      @(negedge clk);
      while (ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      valid <= 1'b0;
      req <= '{addr: ~a, write: 1'b1, byte_acc: ~b}; // Stale request must not linger
      @(negedge clk);
      while (done !== 1'b1) @(negedge clk);
      r = resp;
   endtask : access
endmodule : ocad_cpu_model
`default_nettype wire

// *** ocad_decoder_tb_top.sv ***
/* Testbench of the address decoder: APB master, CPU model, scenarios.
   Assumes the decoder's hand-over timing; no other stimulus source. */
`timescale 1ns/1ps
`default_nettype none
module ocad_decoder_tb_top;
   import ocad_pkg::*;
   logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, slv, boot = 1'b0, valid, ready, done;
   logic [3:0]  seg;
   ocad_req_t   req;
   ocad_resp_t  resp, rsp;
   int          num_errors = 0;
   int          compares = 0;

   ocad_decoder DUT (.REF_CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BOOT_MODE(boot), .ACC_VALID(valid), .ACC_READY(ready),
      .ACC_REQ(req), .ACC_DONE(done), .ACC_RESP(resp), .SEG_LINES(seg));
   ocad_cpu_model u_cpu (.clk(clk), .ready(ready), .done(done), .resp(resp),
      .valid(valid), .req(req));

   // 250 MHz clock
   initial forever #2 clk = ~clk;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One APB transfer; data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic acc(input logic [23:0] a, input logic b, input ocad_target_t t);
      u_cpu.access(a, b, rsp);
      chk("target", 32'(t), 32'(rsp.target));
   endtask : acc

   task automatic t_regs();
      apb(1'b0, 12'h008, '0);
      chk("area2 base", 32'h024, q);
      chk("mapped error", 32'h0, 32'(slv));
      chk("seg lines", 32'h8, 32'(seg));
      apb(1'b0, 12'h100, '0);
      chk("unmapped data", 32'h0, q);
      chk("unmapped error", 32'h1, 32'(slv));
   endtask : t_regs

   task automatic t_map();
      logic [23:0] ad[8] = '{24'h000000, 24'h001fff, 24'h002000, 24'h007fff,
                             24'h018000, 24'h01ffff, 24'h020000, 24'h02ffff};
      logic [2:0]  bk[8] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
      for (int i = 0; i < 8; i++) begin
         acc(ad[i], i[0], OCAD_TGT_FLASH);
         chk("flash block", 32'(bk[i]), 32'(rsp.flash_blk));
      end
      acc(24'h030000, 1'b0, OCAD_TGT_RESERVED);
      acc(24'h04ffff, 1'b1, OCAD_TGT_RESERVED);
      acc(24'h00f600, 1'b1, OCAD_TGT_DUAL_PORT_INTERNAL_RAM);
      acc(24'h00fe00, 1'b0, OCAD_TGT_SFR);
      acc(24'h00f1ff, 1'b0, OCAD_TGT_EXTENDED_FUNCTION_REGS);
   endtask : t_map

   // Area 1 under both enables, external window behind it
   task automatic t_ext_ram_area1();
      apb(1'b1, 12'h014, 32'h00e0);
      apb(1'b1, 12'h024, 32'h1234);
      acc(24'h00e000, 1'b0, OCAD_TGT_EXT);
      chk("window", 32'h1, 32'(rsp.ext_win));
      chk("bus config", 32'h1234, 32'(rsp.ext_cfg));
      apb(1'b1, 12'h000, 32'h4);
      acc(24'h00e7ff, 1'b0, OCAD_TGT_EXT);
      apb(1'b1, 12'h004, 32'h4);
      acc(24'h00e000, 1'b1, OCAD_TGT_EXT_RAM_AREA1);
      acc(24'h00e7ff, 1'b0, OCAD_TGT_EXT_RAM_AREA1);
      acc(24'h00e800, 1'b0, OCAD_TGT_EXT);
   endtask : t_ext_ram_area1

   task automatic t_ext_ram_area2();
      apb(1'b1, 12'h004, 32'h8);
      acc(24'h00e000, 1'b0, OCAD_TGT_EXT);
      acc(24'h090000, 1'b1, OCAD_TGT_EXT_RAM_AREA2);
      acc(24'h091fff, 1'b0, OCAD_TGT_EXT_RAM_AREA2);
      acc(24'h092000, 1'b0, OCAD_TGT_EXT);
      apb(1'b1, 12'h008, 32'h025);
      acc(24'h094000, 1'b0, OCAD_TGT_EXT_RAM_AREA2);
      acc(24'h090000, 1'b0, OCAD_TGT_EXT);
      apb(1'b1, 12'h000, 32'h0);
      acc(24'h094000, 1'b0, OCAD_TGT_EXT);
   endtask : t_ext_ram_area2

   // CAN windows, word only, segment lines cut while a CAN module is enabled
   task automatic t_can();
      apb(1'b1, 12'h000, 32'h4);
      apb(1'b1, 12'h004, 32'h1);
      @(negedge clk);
      chk("seg lines", 32'h4, 32'(seg));
      acc(24'h00ef00, 1'b0, OCAD_TGT_CAN1);
      chk("size error", 32'h0, 32'(rsp.size_err));
      acc(24'h00efff, 1'b1, OCAD_TGT_CAN1);
      chk("size error", 32'h1, 32'(rsp.size_err));
      acc(24'h00ee00, 1'b0, OCAD_TGT_EXT);
      apb(1'b1, 12'h004, 32'h2);
      acc(24'h00eeff, 1'b0, OCAD_TGT_CAN2);
      acc(24'h00ef00, 1'b0, OCAD_TGT_EXT);
      apb(1'b1, 12'h000, 32'h0);
      @(negedge clk);
      chk("seg lines", 32'h8, 32'(seg));
      acc(24'h00eeff, 1'b0, OCAD_TGT_EXT);
   endtask : t_can

   task automatic t_boot();
      @(posedge clk);
      boot <= 1'b1;
      repeat (6) @(posedge clk);
      acc(24'h000000, 1'b0, OCAD_TGT_FLASH);
      chk("flash block", 32'h6, 32'(rsp.flash_blk));
      acc(24'h002000, 1'b0, OCAD_TGT_FLASH);
      chk("flash block", 32'h1, 32'(rsp.flash_blk));
      // Status: ready, strap mode, eight segment lines, last target flash
      apb(1'b0, 12'h00c, '0);
      chk("status", 32'h00000e00, q);
      // The read returns just after a rising edge, so the strap moves there
      boot <= 1'b0;
      repeat (6) @(posedge clk);
      acc(24'h001fff, 1'b0, OCAD_TGT_FLASH);
      chk("flash block", 32'h0, 32'(rsp.flash_blk));
   endtask : t_boot

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   // Main sequence after two reset cycles
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_map();
      t_ext_ram_area1();
      t_ext_ram_area2();
      t_can();
      t_boot();
      end_sim();
   end

   // Watchdog, far beyond the few hundred cycles the scenarios take
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule : ocad_decoder_tb_top
`default_nettype wire
